// file: logic/ivp_defs.vh
// Constants for the input voltage protection register bank.
`ifndef IVP_DEFS_VH
`define IVP_DEFS_VH
// Command codes.
`define IVP_CMD_CLEAR_FAULTS 8'h03
`define IVP_CMD_OV_FAULT_LIM 8'h55
`define IVP_CMD_OV_ACTION 8'h56
`define IVP_CMD_OV_WARN_LIM 8'h57
`define IVP_CMD_UV_WARN_LIM 8'h58
`define IVP_CMD_UV_FAULT_LIM 8'h59
`define IVP_CMD_STATUS_WORD 8'h79
`define IVP_CMD_STATUS_INPUT 8'h7C
// Reset values.
`define IVP_RST_OV_ACTION 8'h80
`define IVP_RST_OV_WARN_LIM 16'hD360
`define IVP_RST_OV_FAULT_LIM 16'hD380
// Fault action fields.
`define IVP_ACT_MODE_HI 7
`define IVP_ACT_MODE_LO 6
`define IVP_ACT_RETRY_HI 5
`define IVP_ACT_RETRY_LO 3
`define IVP_MODE_DISABLE 2'h2
`define IVP_RETRY_NONE 3'h0
`define IVP_RETRY_ENDLESS 3'h7
// Linear-11 fields and internal fixed point.
`define IVP_LIN_EXP_HI 15
`define IVP_LIN_EXP_LO 11
`define IVP_LIN_MANT_HI 10
`define IVP_LIN_FRAC 6'sh08
// Strapped undervoltage fault codes, exponent -4 (1/16 V steps).
`define IVP_STRAP_UV0 16'hE040
`define IVP_STRAP_UV1 16'hE048
`define IVP_STRAP_UV2 16'hE050
`define IVP_STRAP_UV3 16'hE060
`define IVP_UVW_MUL 21'h00000B
`define IVP_UVW_DIV 21'h00000A
`define IVP_UVW_RND 21'h000005
// Status bit positions.
`define IVP_SI_OV_FAULT 7
`define IVP_SI_OV_WARN 6
`define IVP_SI_UV_WARN 5
`define IVP_SI_UV_FAULT 4
`define IVP_SW_INPUT 13
`define IVP_SW_NONE_ABOVE 0
// Timing.
`define IVP_RETRY_MS 70
`define IVP_CLK_KHZ 20000
`define IVP_STRAP_LOAD 2'h2
`endif

// file: logic/ivp_input_voltage_protection_regs.v
// Input voltage protection settings, threshold compare, status flags and fault response.
`timescale 1ns/1ps
`include "ivp_defs.vh"

// What this block does
// - Overvoltage fault action is an 8-bit read/write setting resetting to shutdown, no retry.
// - Action bits 7:6 equal 10 disable the output; other encodings are unused.
// - An overvoltage fault pulls the alert line low and sets its status flag.
// - Fault flags stay set until the clear-faults command; nothing else clears them.
// - Retry setting 000 keeps the output off until faults are cleared.
// - Retry setting 111 restarts endlessly until off, bias loss or another fault.
// - Restarts are spaced a fixed 70 ms; bits 2:0 do not change it.
// - Input above overvoltage warning sets status word bits, input flag and alert.
// - Input below undervoltage warning sets status word bits, input flag and alert.
// - Overvoltage warning threshold is a 16-bit linear value resetting to 13.5 V.
// - Thresholds are linear: signed exponent high, signed mantissa low, volts.
// - Undervoltage warning threshold loads 1.10 times the strapped fault threshold.
// - Undervoltage fault threshold loads from the configuration strap pins.
// - All settings are host read/write and write protectable; host keeps 0 to 19 V.
// - Overvoltage fault threshold resets to 14 V and triggers the fault action.
module ivp_input_voltage_protection_regs #(
  parameter RETRY_CYCLES = `IVP_RETRY_MS * `IVP_CLK_KHZ,
  parameter CNT_W = 21
) (
  // Clock and reset.
  input wire sys_clk,
  input wire resetn,
  // Command port from the host interface logic.
  input wire cmdValid,
  input wire cmdWrite,
  input wire [7:0] cmdCode,
  input wire [15:0] cmdWrData,
  input wire writeProtect,
  output reg [15:0] rdData,
  output reg rdValid,
  // Input voltage measurement, linear format.
  input wire vinValid,
  input wire [15:0] vinCode,
  // Pins.
  input wire [1:0] strapSel,
  input wire controlPin,
  // Other device state.
  input wire operationOff,
  input wire biasLost,
  input wire otherFault,
  // Status and response outputs.
  output reg [7:0] statusInput,
  output reg [15:0] statusWord,
  output reg outputEnable,
  output wire hostAlertLineOut,
  output wire hostAlertLineOeN
);

  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_OFF = 3'h2;
  localparam [2:0] ST_WAIT = 3'h4;

  // Linear-11 to signed fixed point with eight fraction bits.
  function signed [31:0] ivpLinToFix;
    input [15:0] v;
    reg signed [31:0] y;
    reg signed [5:0] e;
    begin
      y = {{21{v[`IVP_LIN_MANT_HI]}}, v[`IVP_LIN_MANT_HI:0]};
      e = {v[`IVP_LIN_EXP_HI], v[`IVP_LIN_EXP_HI:`IVP_LIN_EXP_LO]} + `IVP_LIN_FRAC;
      if (e[5]) begin
        ivpLinToFix = y >>> (-e);
      end else begin
        ivpLinToFix = y <<< e;
      end
    end
  endfunction

  reg [7:0] ovAction_q;
  reg [15:0] ovFaultLim_q;
  reg [15:0] ovWarnLim_q;
  reg [15:0] uvWarnLim_q;
  reg [15:0] uvFaultLim_q;
  reg [1:0] strapMeta_q;
  reg [1:0] strapSync_q;
  reg ctrlMeta_q;
  reg ctrlSync_q;
  reg [1:0] loadCnt_q;
  reg ovFault_q, ovWarn_q, uvWarn_q, uvFault_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [CNT_W-1:0] retryCnt_q;
  reg [15:0] strapCode;
  reg [20:0] strapMant;
  reg [20:0] warnMant;
  reg [15:0] rdMux;

  wire wrOk = cmdValid & cmdWrite & ~writeProtect;
  wire clearFaults = cmdValid & cmdWrite & (cmdCode == `IVP_CMD_CLEAR_FAULTS);
  wire signed [31:0] vinFix = ivpLinToFix(vinCode);
  wire ovFaultHit = vinValid & (vinFix > ivpLinToFix(ovFaultLim_q));
  wire ovWarnHit = vinValid & (vinFix > ivpLinToFix(ovWarnLim_q));
  wire uvWarnHit = vinValid & (vinFix < ivpLinToFix(uvWarnLim_q));
  wire uvFaultHit = vinValid & (vinFix < ivpLinToFix(uvFaultLim_q));
  wire [1:0] actMode = ovAction_q[`IVP_ACT_MODE_HI:`IVP_ACT_MODE_LO];
  wire [2:0] actRetry = ovAction_q[`IVP_ACT_RETRY_HI:`IVP_ACT_RETRY_LO];
  wire shutOff = ctrlSync_q | operationOff;
  wire stopRetry = shutOff | biasLost | otherFault;
  wire anyFlag = ovFault_q | ovWarn_q | uvWarn_q | uvFault_q;

  // Strap and control pins come from outside the clock domain, so two flops first.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strapMeta_q <= 2'h0;
      strapSync_q <= 2'h0;
      ctrlMeta_q <= 1'b0;
      ctrlSync_q <= 1'b0;
    end else begin
      strapMeta_q <= strapSel;
      strapSync_q <= strapMeta_q;
      ctrlMeta_q <= controlPin;
      ctrlSync_q <= ctrlMeta_q;
    end
  end

  // Strapped fault code and its 1.10 scaled warning mantissa, rounded to nearest.
  always @* begin
    case (strapSync_q)
      2'h0: strapCode = `IVP_STRAP_UV0;
      2'h1: strapCode = `IVP_STRAP_UV1;
      2'h2: strapCode = `IVP_STRAP_UV2;
      default: strapCode = `IVP_STRAP_UV3;
    endcase
    strapMant = {{10{strapCode[`IVP_LIN_MANT_HI]}}, strapCode[`IVP_LIN_MANT_HI:0]};
    warnMant = (strapMant * `IVP_UVW_MUL + `IVP_UVW_RND) / `IVP_UVW_DIV;
  end

  // Settings registers. The strap is sampled a few edges after release, once the
  // synchroniser holds the pin level, since an async reset may only load constants.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ovAction_q <= `IVP_RST_OV_ACTION;
      ovFaultLim_q <= `IVP_RST_OV_FAULT_LIM;
      ovWarnLim_q <= `IVP_RST_OV_WARN_LIM;
      uvWarnLim_q <= 16'h0000;
      uvFaultLim_q <= 16'h0000;
      loadCnt_q <= 2'h0;
    end else begin
      if (loadCnt_q != 2'h3) begin
        loadCnt_q <= loadCnt_q + 2'h1;
      end
      if (loadCnt_q == `IVP_STRAP_LOAD) begin
        uvFaultLim_q <= strapCode;
        uvWarnLim_q <= {strapCode[`IVP_LIN_EXP_HI:`IVP_LIN_EXP_LO], warnMant[`IVP_LIN_MANT_HI:0]};
      end else if (wrOk) begin
        // Writes are refused while write protect is high; range is left to the host.
        case (cmdCode)
          `IVP_CMD_OV_FAULT_LIM: ovFaultLim_q <= cmdWrData;
          `IVP_CMD_OV_ACTION: ovAction_q <= cmdWrData[7:0];
          `IVP_CMD_OV_WARN_LIM: ovWarnLim_q <= cmdWrData;
          `IVP_CMD_UV_WARN_LIM: uvWarnLim_q <= cmdWrData;
          `IVP_CMD_UV_FAULT_LIM: uvFaultLim_q <= cmdWrData;
          default: ovAction_q <= ovAction_q;
        endcase
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle wins over the clear.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ovFault_q <= 1'b0;
      ovWarn_q <= 1'b0;
      uvWarn_q <= 1'b0;
      uvFault_q <= 1'b0;
    end else begin
      ovFault_q <= (ovFault_q & ~clearFaults) | ovFaultHit;
      ovWarn_q <= (ovWarn_q & ~clearFaults) | ovWarnHit;
      uvWarn_q <= (uvWarn_q & ~clearFaults) | uvWarnHit;
      uvFault_q <= (uvFault_q & ~clearFaults) | uvFaultHit;
    end
  end

  // Status images follow the sticky flags.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      statusInput <= 8'h00;
      statusWord <= 16'h0000;
    end else begin
      statusInput <= 8'h00;
      statusInput[`IVP_SI_OV_FAULT] <= ovFault_q;
      statusInput[`IVP_SI_OV_WARN] <= ovWarn_q;
      statusInput[`IVP_SI_UV_WARN] <= uvWarn_q;
      statusInput[`IVP_SI_UV_FAULT] <= uvFault_q;
      statusWord <= 16'h0000;
      statusWord[`IVP_SW_INPUT] <= anyFlag;
      statusWord[`IVP_SW_NONE_ABOVE] <= anyFlag;
    end
  end

  // Alert is open drain: the enable goes low to pull the line down while any flag stands.
  assign hostAlertLineOut = 1'b0;
  assign hostAlertLineOeN = ~(statusInput != 8'h00);

  // Fault response. Unused mode or retry codes degrade to the safest reading:
  // an unused mode only flags, an unused retry code behaves as no retry.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (ovFaultHit && actMode == `IVP_MODE_DISABLE) begin
          if (actRetry == `IVP_RETRY_ENDLESS && !stopRetry) begin
            state_d = ST_WAIT;
          end else begin
            state_d = ST_OFF;
          end
        end
      end
      ST_OFF: begin
        if (clearFaults && !ovFaultHit) begin
          state_d = ST_RUN;
        end
      end
      ST_WAIT: begin
        if (stopRetry) begin
          state_d = ST_OFF;
        end else if (retryCnt_q == RETRY_CYCLES[CNT_W-1:0] - 1'b1) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  // The retry interval ignores action bits 2:0 entirely.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_RUN;
      retryCnt_q <= {CNT_W{1'b0}};
      outputEnable <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_WAIT) begin
        retryCnt_q <= retryCnt_q + 1'b1;
      end else begin
        retryCnt_q <= {CNT_W{1'b0}};
      end
      outputEnable <= (state_d == ST_RUN) & ~shutOff & ~biasLost;
    end
  end

  // Read mux; unmapped codes read as zero.
  always @* begin
    case (cmdCode)
      `IVP_CMD_OV_FAULT_LIM: rdMux = ovFaultLim_q;
      `IVP_CMD_OV_ACTION: rdMux = {8'h00, ovAction_q};
      `IVP_CMD_OV_WARN_LIM: rdMux = ovWarnLim_q;
      `IVP_CMD_UV_WARN_LIM: rdMux = uvWarnLim_q;
      `IVP_CMD_UV_FAULT_LIM: rdMux = uvFaultLim_q;
      `IVP_CMD_STATUS_WORD: rdMux = statusWord;
      `IVP_CMD_STATUS_INPUT: rdMux = {8'h00, statusInput};
      default: rdMux = 16'h0000;
    endcase
  end

  // Read answer one cycle after the request.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= 16'h0000;
      rdValid <= 1'b0;
    end else begin
      rdValid <= cmdValid & ~cmdWrite;
      if (cmdValid && !cmdWrite) begin
        rdData <= rdMux;
      end
    end
  end

endmodule // ivp_input_voltage_protection_regs

// file: verif/ivp_checker_props.sv
// Port checker for the input protection bank.
`timescale 1ns/1ps
module ivp_checker (
  // Clock and reset.
  input wire sys_clk,
  input wire resetn,
  // Inputs.
  input wire cmdValid,
  input wire cmdWrite,
  input wire [7:0] cmdCode,
  input wire vinValid,
  input wire operationOff,
  input wire biasLost,
  // Outputs.
  input wire rdValid,
  input wire [7:0] statusInput,
  input wire [15:0] statusWord,
  input wire outputEnable,
  input wire hostAlertLineOut,
  input wire hostAlertLineOeN
);
  // Decoded clear command and the four input flags.
  wire clrCmd = cmdValid && cmdWrite && cmdCode == 8'h03;
  wire [3:0] fl = statusInput[7:4];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // A read, and a clear with no measurement close behind it.
  sequence rdReq;
    cmdValid && !cmdWrite;
  endsequence
  sequence clrQuiet;
    (clrCmd && !vinValid) ##1 !vinValid ##1 !vinValid;
  endsequence
  AST_RD_ANS: assert property (rdReq |=> rdValid) else $error("no answer");
  AST_RD_ONLY: assert property (!(cmdValid && !cmdWrite) |=> !rdValid) else $error("stray answer");
  AST_ALERT: assert property (hostAlertLineOeN == (fl == 4'h0)) else $error("alert wrong");
  AST_ALERT_LOW: assert property (hostAlertLineOut == 1'b0) else $error("alert level");
  AST_WORD: assert property ({statusWord[13], statusWord[0]} == {2{|fl}}) else $error("word wrong");
  AST_HOLD: assert property (|($past(fl) & ~fl) |-> $past(clrCmd, 2) || $past(clrCmd, 3)) else $error("flag lost");
  AST_RISE: assert property (|(fl & ~$past(fl)) |-> $past(vinValid) || $past(vinValid, 2)) else $error("no cause");
  AST_CLEAR: assert property (clrQuiet |-> ##1 (fl == 4'h0 && hostAlertLineOeN)) else $error("not cleared");
  AST_OE_ON: assert property ($rose(outputEnable) |-> !$past(biasLost) && !$past(operationOff)) else $error("bad on");
endmodule // ivp_checker

// file: verif/ivp_host_model.sv
// Host model driving the command port.
`timescale 1ns/1ps
module ivp_host_model (
  // Clock.
  input wire sys_clk,
  // Command port.
  output logic cmdValid = 1'b0,
  output logic cmdWrite = 1'b0,
  output logic [7:0] cmdCode = 8'h00,
  output logic [15:0] cmdWrData = 16'h0000,
  input wire [15:0] rdData,
  input wire rdValid
);
  // One command per call; a gap cycle follows so strobes never merge.
  task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(negedge sys_clk);
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdCode = code;
    cmdWrData = data;
    @(negedge sys_clk);
    cmdValid = 1'b0;
    cmdWrData = ~data; // Released data shows garbage, not the old word.
  endtask
  // The answer pulse stands for the cycle after the taking edge.
  task automatic read(input logic [7:0] code, output logic [15:0] data, output logic ok);
    send(1'b0, code, 16'h0000);
    ok = rdValid;
    data = rdData;
  endtask
endmodule // ivp_host_model

// file: verif/tb_top.sv
// Bench for the input protection bank.
`timescale 1ns/1ps
`include "ivp_defs.vh"
module tb_top;
  localparam int RETRY = 20;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic writeProtect = 1'b0;
  logic vinValid = 1'b0;
  logic biasLost = 1'b0;
  logic ctrlPin = 1'b0;
  logic opOff = 1'b0;
  logic othF = 1'b0;
  logic [15:0] vinCode = 16'h0000;
  logic [1:0] strapSel = 2'h0;
  wire cmdValid, cmdWrite, rdValid, outputEnable, aOut, aOeN;
  wire [7:0] cmdCode, statusInput;
  wire [15:0] cmdWrData, rdData, statusWord;
  wire alertWire = aOeN ? 1'b1 : aOut; // Pull-up holds the released line.
  int miscompares = 0;
  int num_checks = 0;
  int seed = 90;
  int k, d0, d;
  logic [15:0] v, got;
  logic [7:0] n;
  logic ok;
  logic [15:0] strapTbl [4] = '{`IVP_STRAP_UV0, `IVP_STRAP_UV1, `IVP_STRAP_UV2, `IVP_STRAP_UV3};
  logic [15:0] cfg [5] = '{16'hE130, 16'h0080, 16'hE0D8, 16'hE050, 16'hE040};
  always #25 sys_clk = ~sys_clk;
  ivp_input_voltage_protection_regs #(.RETRY_CYCLES(RETRY), .CNT_W(21)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData), .writeProtect(writeProtect),
    .rdData(rdData), .rdValid(rdValid), .vinValid(vinValid), .vinCode(vinCode), .strapSel(strapSel),
    .controlPin(ctrlPin), .operationOff(opOff), .biasLost(biasLost), .otherFault(othF), .statusInput(statusInput),
    .statusWord(statusWord), .outputEnable(outputEnable), .hostAlertLineOut(aOut), .hostAlertLineOeN(aOeN));
  ivp_host_model host (.sys_clk(sys_clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdWrData(cmdWrData), .rdData(rdData), .rdValid(rdValid));
  // Warning level is 1.1 times the fault mantissa, rounded, same exponent.
  function automatic logic [15:0] warnOf(input logic [15:0] f);
    warnOf = {f[15:11], 11'((f[10:0] * 11 + 5) / 10)};
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", what, exp, seen);
    end
  endtask
  task automatic rdChk(input logic [7:0] code, input logic [15:0] exp);
    host.read(code, got, ok);
    check("rdValid", 16'h0001, {15'h0000, ok});
    check("rdData", exp, got);
  endtask
  // One measurement pulse, then time for the status registers to follow.
  task automatic meas(input logic [15:0] code);
    @(negedge sys_clk);
    vinValid = 1'b1;
    vinCode = code;
    @(negedge sys_clk);
    vinValid = 1'b0;
    vinCode = ~code;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic st(input logic [3:0] f, input logic oe);
    check("flags", {12'h000, f}, {12'h000, statusInput[7:4]});
    check("word", {14'h0000, {2{|f}}}, {14'h0000, statusWord[13], statusWord[0]});
    check("alert", {15'h0000, ~|f}, {15'h0000, alertWire});
    check("outEn", {15'h0000, oe}, {15'h0000, outputEnable});
  endtask
  task automatic clr;
    host.send(1'b1, 8'h03, 16'h0000);
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic finish_test;
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog sized well past the few hundred cycles the sequence needs.
  initial begin
    #2000000;
    miscompares++;
    finish_test();
  end
  // Main sequence.
  initial begin
    v = $random(seed);
    strapSel = v[1:0];
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (5) @(negedge sys_clk);
    rdChk(8'h56, 16'h0080);
    rdChk(8'h57, 16'hD360);
    rdChk(8'h55, 16'hD380);
    rdChk(8'h59, strapTbl[strapSel]);
    rdChk(8'h58, warnOf(strapTbl[strapSel]));
    for (k = 0; k < 10; k++) begin
      n = 8'(8'h55 + k % 5);
      v = {(n == 8'h56) ? 8'h00 : 8'hE0, 8'($random(seed))};
      host.send(1'b1, n, v);
      rdChk(n, v);
    end
    for (k = 0; k < 5; k++) host.send(1'b1, 8'(8'h55 + k), cfg[k]);
    writeProtect = 1'b1;
    host.send(1'b1, 8'h57, 16'hE0F0);
    writeProtect = 1'b0;
    host.send(1'b1, 8'h5A, 16'hE0F0);
    rdChk(8'h57, 16'hE0D8);
    meas(16'hE0E0);
    st(4'h4, 1'b1);
    meas(16'hE0D8);
    st(4'h4, 1'b1);
    clr();
    meas(16'hE048);
    st(4'h2, 1'b1);
    clr();
    meas(16'hE030);
    st(4'h3, 1'b1);
    clr();
    st(4'h0, 1'b1);
    meas(16'hE140);
    repeat (RETRY + 10) @(negedge sys_clk);
    st(4'hC, 1'b0);
    clr();
    st(4'h0, 1'b1);
    host.send(1'b1, 8'h56, 16'h0038);
    meas(16'hE140);
    st(4'hC, 1'b1);
    clr();
    // Endless retry, spare bits zero then random: the spacing must not move.
    for (k = 0; k < 2; k++) begin
      host.send(1'b1, 8'h56, {8'h00, 5'h17, k ? 3'($random(seed)) : 3'h0});
      meas(16'hE140);
      d = 0;
      while (outputEnable !== 1'b1 && d < 200) begin
        @(negedge sys_clk);
        d++;
      end
      if (k == 0) d0 = d;
      check("span", 16'(d0), 16'(d));
      st(4'hC, 1'b1);
    end
    // Fault edge to enable seen at the falling edge: the retry count less the three cycles meas spends.
    check("spanLen", 16'(RETRY - 3), 16'(d));
    meas(16'hE140);
    biasLost = 1'b1;
    repeat (RETRY + 10) @(negedge sys_clk);
    st(4'hC, 1'b0);
    biasLost = 1'b0;
    clr();
    st(4'h0, 1'b1);
    // Commanded off by the operation input and by the control pin, then another fault while retrying.
    opOff = 1'b1;
    repeat (2) @(negedge sys_clk);
    st(4'h0, 1'b0);
    opOff = 1'b0;
    ctrlPin = 1'b1;
    repeat (4) @(negedge sys_clk);
    st(4'h0, 1'b0);
    ctrlPin = 1'b0;
    repeat (4) @(negedge sys_clk);
    st(4'h0, 1'b1);
    meas(16'hE140);
    othF = 1'b1;
    repeat (RETRY + 10) @(negedge sys_clk);
    othF = 1'b0;
    repeat (2) @(negedge sys_clk);
    st(4'hC, 1'b0);
    clr();
    st(4'h0, 1'b1);
    finish_test();
  end
endmodule // tb_top
bind ivp_input_voltage_protection_regs ivp_checker chk (.sys_clk(sys_clk), .resetn(resetn), .cmdValid(cmdValid),
  .cmdWrite(cmdWrite), .cmdCode(cmdCode), .vinValid(vinValid), .operationOff(operationOff), .biasLost(biasLost),
  .rdValid(rdValid), .statusInput(statusInput), .statusWord(statusWord), .outputEnable(outputEnable),
  .hostAlertLineOut(hostAlertLineOut), .hostAlertLineOeN(hostAlertLineOeN));
